/* design/srap_port.sv */
// Purpose: 2-wire serial slave giving access to the colour matrix unit registers.
// Assumes: SCL_I clocks the link logic; SDA_I is data of that clock domain.
// Notes:   Writes cross to CLK_I by toggle handshake; reads see quasi-static flops.
`timescale 1ns/1ns

module srap_port
  import srap_pkg::*;
(
  // System clock and reset
  input  wire logic         CLK_I,
  input  wire logic         NRST_I,
  // Serial link
  input  wire logic         SCL_I,
  input  wire logic         SDA_I,
  output logic              SDA_O,
  output logic              SDA_OE_O,
  // Strap pin
  input  wire logic         ADDRESS_SELECT_PIN_I,
  // Coefficients to the colour matrix unit, byte i at bits [8i+7:8i]
  output logic [8*CSC_NUM-1:0] COEFF_O
);

  // True when the address falls in the colour matrix unit window
  function automatic logic in_csc(input logic [7:0] addr);
    in_csc = (addr >= CSC_FIRST) && (addr <= CSC_LAST);
  endfunction

  // Array index of an address in the window
  function automatic logic [4:0] csc_idx(input logic [7:0] addr);
    logic [7:0] diff;
    diff    = addr - CSC_FIRST;
    csc_idx = diff[4:0];
  endfunction

  // Next pointer, held at the top address instead of wrapping
  // Shared by the write path and the read path, so both saturate alike
  function automatic logic [7:0] sat_inc(input logic [7:0] addr);
    sat_inc = (addr >= CSC_LAST) ? CSC_LAST : addr + 8'h01;
  endfunction

  // Start detector (clocked by the data line)
  logic              start_tgl_r;
  // Link domain, rising edge
  logic [8:0]        rx_sh_r;
  logic              sel_meta_r;
  logic              sel_r;
  // Link domain, falling edge
  srap_state_e       state_r;
  srap_state_e       state_nxt;
  logic [3:0]        cnt_r;
  logic [3:0]        cnt_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic [7:0]        tx_r;
  logic [7:0]        tx_nxt;
  logic [7:0]        ptr_r;
  logic [7:0]        ptr_nxt;
  logic              start_seen_r;
  logic [7:0]        wr_addr_r;
  logic [7:0]        wr_addr_nxt;
  logic [7:0]        wr_data_r;
  logic [7:0]        wr_data_nxt;
  logic              wr_tgl_r;
  logic              wr_tgl_nxt;
  // System clock domain
  logic              wr_meta_r;
  logic              wr_sync_r;
  logic              wr_seen_r;
  logic [7:0]        coeff_r [CSC_NUM];

  // Decodes used by the link state machine and by the system-domain write path
  wire logic         start_pend;
  wire logic         at_last_bit;
  wire logic         at_ack;
  wire logic [7:0]   rx_byte;
  wire logic [7:0]   rx_byte_ack;
  wire logic         addr_match;
  wire logic         rw_bit;
  wire logic         mst_nack;
  wire logic         base_ok;
  wire logic [7:0]   rd_data;
  wire logic         wr_event;
  wire logic         wr_hit;

  assign start_pend  = start_tgl_r != start_seen_r;
  assign at_last_bit = cnt_r == CNT_LAST_BIT;
  assign at_ack      = cnt_r == CNT_ACK;
  assign rx_byte     = rx_sh_r[7:0];          // Full byte just after its 8th bit
  assign rx_byte_ack = rx_sh_r[8:1];          // Same byte once the ack bit shifted in
  assign addr_match  = rx_byte[7:1] == {SLV_ADDR_HI, sel_r};
  assign rw_bit      = rx_byte_ack[0];
  assign mst_nack    = rx_sh_r[0];            // Level seen in the ack slot
  assign base_ok     = rx_byte <= CSC_LAST;
  // Read path: flops in the system domain, stable while the link reads them
  // Limitation: a byte is fetched at the ack slot before it is shifted out, so
  // a write must have crossed first; the protocol leaves eleven link clocks
  assign rd_data     = in_csc(ptr_r) ? coeff_r[csc_idx(ptr_r)] : 8'h00;
  // Write path decode in the system domain
  assign wr_event    = wr_sync_r != wr_seen_r;
  assign wr_hit      = wr_event && in_csc(wr_addr_r);

  // Open-drain data line: only ever pulls low
  // The pull-up outside gives the high level; a released line reads as one
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = oe_r;

  // Data line falling while the clock is high marks a (repeated) start
  // The toggle is compared with a copy taken on each clock fall, so a start
  // is acted on at the first fall after it, whatever state the frame is in
  // A stop is not decoded: the port has already released the line by then
  always_ff @(negedge SDA_I or negedge NRST_I)
  begin
    if (!NRST_I)
      start_tgl_r <= 1'b0;
    else if (SCL_I)
      start_tgl_r <= ~start_tgl_r;
  end

  // Sample data on the rising clock edge; a start re-aligns the byte count
  // Nine bits are kept so that a finished byte is still whole after the
  // acknowledge bit has shifted in behind it
  always_ff @(posedge SCL_I or negedge NRST_I)
  begin
    if (!NRST_I)
      rx_sh_r <= 9'h000;
    else
      rx_sh_r <= {rx_sh_r[7:0], SDA_I};
  end

  // Two-stage capture of the address select strap
  // The strap is static in use; the two flops only guard a change while idle
  // After reset the address only matches once two clock pulses have passed
  always_ff @(posedge SCL_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sel_meta_r <= 1'b0;
      sel_r      <= 1'b0;
    end
    else
    begin
      sel_meta_r <= ADDRESS_SELECT_PIN_I;
      sel_r      <= sel_meta_r;
    end
  end

  // Link state machine: every change happens while the clock is low
  // Acting on the falling edge keeps the data line steady across each high
  // phase, so the master never sees our edges as a start or a stop
  // Priority: a pending start, then the ack slot, then the eighth bit
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    oe_nxt      = oe_r;
    tx_nxt      = tx_r;
    ptr_nxt     = ptr_r;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    wr_tgl_nxt  = wr_tgl_r;
    if (start_pend)
    begin
      // A start always wins and restarts with the address byte
      state_nxt = SRAP_DEV;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end
    else if (at_ack)
    begin
      // Leave the ack slot and act on the byte just finished
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
      unique case (state_r)
        SRAP_IDLE:
          state_nxt = SRAP_IDLE;
        SRAP_DEV:
        begin
          if (!oe_r)
            state_nxt = SRAP_IDLE;
          else if (rw_bit)
          begin
            state_nxt = SRAP_RDATA;
            tx_nxt    = rd_data;
            oe_nxt    = ~rd_data[7];
          end
          else
            state_nxt = SRAP_REG;
        end
        SRAP_REG:
        begin
          if (!oe_r)
            state_nxt = SRAP_IDLE;
          else
          begin
            state_nxt = SRAP_WDATA;
            ptr_nxt   = rx_byte_ack;
          end
        end
        SRAP_WDATA:
          state_nxt = SRAP_WDATA;
        SRAP_RDATA:
        begin
          if (mst_nack)
            state_nxt = SRAP_IDLE;
          else
          begin
            tx_nxt = rd_data;
            oe_nxt = ~rd_data[7];
          end
        end
      endcase
    end
    else if (at_last_bit)
    begin
      // Eighth bit done: decide on the acknowledge
      cnt_nxt = CNT_ACK;
      unique case (state_r)
        SRAP_IDLE:
          oe_nxt = 1'b0;
        SRAP_DEV:
          oe_nxt = addr_match;
        SRAP_REG:
          oe_nxt = base_ok;
        SRAP_WDATA:
        begin
          oe_nxt      = 1'b1;
          wr_addr_nxt = ptr_r;
          wr_data_nxt = rx_byte;
          wr_tgl_nxt  = ~wr_tgl_r;
          ptr_nxt     = sat_inc(ptr_r);
        end
        SRAP_RDATA:
        begin
          oe_nxt  = 1'b0;                     // Master owns the ack slot
          ptr_nxt = sat_inc(ptr_r);
        end
      endcase
    end
    else
    begin
      // Inside a byte: count, and shift out read data MSB first
      cnt_nxt = cnt_r + 4'h1;
      if (state_r == SRAP_RDATA)
      begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = ~tx_r[6];
      end
      else
        oe_nxt = 1'b0;
    end
  end

  // Link state registers on the falling clock edge
  always_ff @(negedge SCL_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_r      <= SRAP_IDLE;
      cnt_r        <= 4'h0;
      oe_r         <= 1'b0;
      tx_r         <= 8'h00;
      ptr_r        <= 8'h00;
      start_seen_r <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      oe_r         <= oe_nxt;
      tx_r         <= tx_nxt;
      ptr_r        <= ptr_nxt;
      start_seen_r <= start_tgl_r;
    end
  end

  // Write request held stable until the next write byte
  // Address and data change together with the toggle and then stand for a
  // whole byte of nine link clocks, well beyond the three system clocks the
  // synchroniser needs, so no wider handshake is required
  always_ff @(negedge SCL_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_tgl_r  <= 1'b0;
    end
    else
    begin
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      wr_tgl_r  <= wr_tgl_nxt;
    end
  end

  // Bring the write toggle into the system clock domain
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wr_meta_r <= 1'b0;
      wr_sync_r <= 1'b0;
      wr_seen_r <= 1'b0;
    end
    else
    begin
      wr_meta_r <= wr_tgl_r;
      wr_sync_r <= wr_meta_r;
      wr_seen_r <= wr_sync_r;
    end
  end

  // Coefficient store: defaults at reset, updated only by serial writes
  // Writes below the window are acknowledged on the link but dropped here
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      for (int i = 0; i < CSC_NUM; i++)
        coeff_r[i] <= CSC_RESET[i];
    end
    else if (wr_hit)
      coeff_r[csc_idx(wr_addr_r)] <= wr_data_r;
  end

  // Present the store to the colour matrix unit
  always_comb
  begin
    for (int i = 0; i < CSC_NUM; i++)
      COEFF_O[i*8 +: 8] = coeff_r[i];
  end

endmodule

/* design/srap_pkg.sv */
// Purpose: Shared constants and types for the 2-wire serial register access port.
// Assumes: Byte-wide registers; the colour matrix unit block spans 0x35..0x4c.
// Notes:   Each offset is paired with its reset value on one line.
package srap_pkg;

  // Device address: upper six bits fixed, lowest bit from the address select pin
  localparam logic [5:0] SLV_ADDR_HI = 6'h26;

  // Bit counter: 0..7 are data bits, 8 is the acknowledge slot
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK      = 4'h8;

  // Colour matrix unit register window
  localparam int         CSC_NUM   = 24;
  localparam logic [7:0] CSC_FIRST = 8'h35;
  localparam logic [7:0] CSC_LAST  = 8'h4c;

  // Register offsets and reset values (full-range HD luma/chroma to full-range RGB)
  localparam logic [7:0] CSC_RED_COEFF1_BYTE_A_OFS = 8'h35, CSC_RED_COEFF1_BYTE_A_RST = 8'h0c;
  localparam logic [7:0] CSC_RED_COEFF1_BYTE_B_OFS = 8'h36, CSC_RED_COEFF1_BYTE_B_RST = 8'h52;
  localparam logic [7:0] CSC_RED_COEFF2_BYTE_A_OFS = 8'h37, CSC_RED_COEFF2_BYTE_A_RST = 8'h08;
  localparam logic [7:0] CSC_RED_COEFF2_BYTE_B_OFS = 8'h38, CSC_RED_COEFF2_BYTE_B_RST = 8'h00;
  localparam logic [7:0] CSC_RED_COEFF3_BYTE_A_OFS = 8'h39, CSC_RED_COEFF3_BYTE_A_RST = 8'h00;
  localparam logic [7:0] CSC_RED_COEFF3_BYTE_B_OFS = 8'h3a, CSC_RED_COEFF3_BYTE_B_RST = 8'h00;
  localparam logic [7:0] CSC_RED_OFFSET_BYTE_A_OFS = 8'h3b, CSC_RED_OFFSET_BYTE_A_RST = 8'h19;
  localparam logic [7:0] CSC_RED_OFFSET_BYTE_B_OFS = 8'h3c, CSC_RED_OFFSET_BYTE_B_RST = 8'hd7;
  localparam logic [7:0] CSC_GREEN_COEFF1_BYTE_A_OFS = 8'h3d, CSC_GREEN_COEFF1_BYTE_A_RST = 8'h1c;
  localparam logic [7:0] CSC_GREEN_COEFF1_BYTE_B_OFS = 8'h3e, CSC_GREEN_COEFF1_BYTE_B_RST = 8'h54;
  localparam logic [7:0] CSC_GREEN_COEFF2_BYTE_A_OFS = 8'h3f, CSC_GREEN_COEFF2_BYTE_A_RST = 8'h08;
  localparam logic [7:0] CSC_GREEN_COEFF2_BYTE_B_OFS = 8'h40, CSC_GREEN_COEFF2_BYTE_B_RST = 8'h00;
  localparam logic [7:0] CSC_GREEN_COEFF3_BYTE_A_OFS = 8'h41, CSC_GREEN_COEFF3_BYTE_A_RST = 8'h3e;
  localparam logic [7:0] CSC_GREEN_COEFF3_BYTE_B_OFS = 8'h42, CSC_GREEN_COEFF3_BYTE_B_RST = 8'h89;
  localparam logic [7:0] CSC_GREEN_OFFSET_BYTE_A_OFS = 8'h43, CSC_GREEN_OFFSET_BYTE_A_RST = 8'h02;
  localparam logic [7:0] CSC_GREEN_OFFSET_BYTE_B_OFS = 8'h44, CSC_GREEN_OFFSET_BYTE_B_RST = 8'h91;
  localparam logic [7:0] CSC_BLUE_COEFF1_BYTE_A_OFS = 8'h45, CSC_BLUE_COEFF1_BYTE_A_RST = 8'h00;
  localparam logic [7:0] CSC_BLUE_COEFF1_BYTE_B_OFS = 8'h46, CSC_BLUE_COEFF1_BYTE_B_RST = 8'h00;
  localparam logic [7:0] CSC_BLUE_COEFF2_BYTE_A_OFS = 8'h47, CSC_BLUE_COEFF2_BYTE_A_RST = 8'h08;
  localparam logic [7:0] CSC_BLUE_COEFF2_BYTE_B_OFS = 8'h48, CSC_BLUE_COEFF2_BYTE_B_RST = 8'h00;
  localparam logic [7:0] CSC_BLUE_COEFF3_BYTE_A_OFS = 8'h49, CSC_BLUE_COEFF3_BYTE_A_RST = 8'h0e;
  localparam logic [7:0] CSC_BLUE_COEFF3_BYTE_B_OFS = 8'h4a, CSC_BLUE_COEFF3_BYTE_B_RST = 8'h87;
  localparam logic [7:0] CSC_BLUE_OFFSET_BYTE_A_OFS = 8'h4b, CSC_BLUE_OFFSET_BYTE_A_RST = 8'h18;
  localparam logic [7:0] CSC_BLUE_OFFSET_BYTE_B_OFS = 8'h4c, CSC_BLUE_OFFSET_BYTE_B_RST = 8'hbd;

  // Reset image indexed by (offset - CSC_FIRST)
  localparam logic [7:0] CSC_RESET [CSC_NUM] = '{
    CSC_RED_COEFF1_BYTE_A_RST, CSC_RED_COEFF1_BYTE_B_RST,
    CSC_RED_COEFF2_BYTE_A_RST, CSC_RED_COEFF2_BYTE_B_RST,
    CSC_RED_COEFF3_BYTE_A_RST, CSC_RED_COEFF3_BYTE_B_RST,
    CSC_RED_OFFSET_BYTE_A_RST, CSC_RED_OFFSET_BYTE_B_RST,
    CSC_GREEN_COEFF1_BYTE_A_RST, CSC_GREEN_COEFF1_BYTE_B_RST,
    CSC_GREEN_COEFF2_BYTE_A_RST, CSC_GREEN_COEFF2_BYTE_B_RST,
    CSC_GREEN_COEFF3_BYTE_A_RST, CSC_GREEN_COEFF3_BYTE_B_RST,
    CSC_GREEN_OFFSET_BYTE_A_RST, CSC_GREEN_OFFSET_BYTE_B_RST,
    CSC_BLUE_COEFF1_BYTE_A_RST, CSC_BLUE_COEFF1_BYTE_B_RST,
    CSC_BLUE_COEFF2_BYTE_A_RST, CSC_BLUE_COEFF2_BYTE_B_RST,
    CSC_BLUE_COEFF3_BYTE_A_RST, CSC_BLUE_COEFF3_BYTE_B_RST,
    CSC_BLUE_OFFSET_BYTE_A_RST, CSC_BLUE_OFFSET_BYTE_B_RST
  };

  // Link-side transfer phases
  typedef enum logic [4:0] {
    SRAP_IDLE  = 5'b00001,
    SRAP_DEV   = 5'b00010,
    SRAP_REG   = 5'b00100,
    SRAP_WDATA = 5'b01000,
    SRAP_RDATA = 5'b10000
  } srap_state_e;

endpackage

/* verif/srap_port_assertions.sv */
// Purpose: Link and register checks on the serial register access port.
// Assumes: SCL rests high between frames; SDA is the resolved line level.
// Notes:   Link checks sample on SCL rise, coefficient checks on CLK_I.
`timescale 1ns/1ns
module srap_port_checker
  import srap_pkg::*;
(
  input wire logic                 CLK_I,
  input wire logic                 NRST_I,
  input wire logic                 SCL_I,
  input wire logic                 SDA_I,
  input wire logic                 SDA_O,
  input wire logic                 SDA_OE_O,
  input wire logic                 ADDRESS_SELECT_PIN_I,
  input wire logic [8*CSC_NUM-1:0] COEFF_O
);
  logic                 tg_r, seen_r, acc_r, rd_r;
  logic [3:0]           cnt_r;
  logic [1:0]           nb_r;
  logic [7:0]           sh_r, ptr_r;
  logic [8*CSC_NUM-1:0] img;
  // Frame decodes: fresh start, ack slot, device data bit, byte read back
  wire       new_w = tg_r != seen_r;
  wire       ack_w = !new_w && cnt_r == 4'h8;
  wire       dat_w = !new_w && cnt_r != 4'h8 && acc_r && rd_r && nb_r != 2'h0;
  wire       in_w  = ptr_r >= CSC_FIRST && ptr_r <= CSC_LAST;
  wire [7:0] rby_w = in_w ? COEFF_O[(ptr_r - CSC_FIRST) * 8 +: 8] : 8'h00;
  // Reset image of the coefficient bus
  for (genvar i = 0; i < CSC_NUM; i++)
  begin : g_img
    assign img[8*i +: 8] = CSC_RESET[i];
  end
  // Start marker: SDA falling while SCL is high
  always_ff @(negedge SDA_I or negedge NRST_I)
    if (!NRST_I)
      tg_r <= 1'b0;
    else if (SCL_I)
      tg_r <= ~tg_r;
  // Bit, byte, direction and pointer tracking; ack slot qualifies the frame
  always_ff @(posedge SCL_I or negedge NRST_I)
    if (!NRST_I)
    begin
      {seen_r, acc_r, rd_r, cnt_r, nb_r} <= '0;
      {sh_r, ptr_r} <= '0;
    end
    else if (ack_w)
    begin
      cnt_r <= 4'h0;
      nb_r  <= nb_r + {1'b0, nb_r != 2'h3};
      acc_r <= (nb_r == 2'h0) ? SDA_OE_O : acc_r & (rd_r ? !SDA_I : SDA_OE_O);
      rd_r  <= (nb_r == 2'h0) ? sh_r[0] : rd_r;
      ptr_r <= (nb_r == 2'h1 && !rd_r) ? sh_r
             : ptr_r + {7'h00, ptr_r != CSC_LAST && nb_r != 2'h0};
    end
    else
    begin
      seen_r <= tg_r;
      cnt_r  <= new_w ? 4'h1 : cnt_r + 4'h1;
      nb_r   <= new_w ? 2'h0 : nb_r;
      sh_r   <= {sh_r[6:0], SDA_I};
    end
  addr_ack_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    ack_w && nb_r == 2'h0 |-> SDA_OE_O == (sh_r[7:1] == {SLV_ADDR_HI, ADDRESS_SELECT_PIN_I}))
    else $error("address ack wrong");
  base_ack_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    ack_w && nb_r == 2'h1 && !rd_r |-> SDA_OE_O == (acc_r && sh_r <= CSC_LAST))
    else $error("base ack wrong");
  data_ack_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    ack_w && nb_r[1] && !rd_r |-> SDA_OE_O == acc_r)
    else $error("data ack wrong");
  line_quiet_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    !ack_w && !dat_w |-> !SDA_OE_O)
    else $error("line driven out of turn");
  read_release_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    ack_w && rd_r && nb_r != 2'h0 |-> !SDA_OE_O)
    else $error("master ack slot driven");
  read_bit_a: assert property (@(posedge SCL_I) disable iff (!NRST_I)
    dat_w |-> SDA_OE_O == !rby_w[~cnt_r[2:0]])
    else $error("read bit wrong");
  coeff_hold_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $changed(COEFF_O) |-> acc_r && !rd_r && nb_r[1])
    else $error("coefficient changed outside write");
  coeff_reset_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(NRST_I) |-> COEFF_O == img)
    else $error("coefficient reset image wrong");
  cover property (@(posedge SCL_I) ack_w && nb_r == 2'h0 && SDA_OE_O);
  cover property (@(posedge SCL_I) dat_w);
  cover property (@(posedge SCL_I) ack_w && nb_r == 2'h1 && acc_r && !SDA_OE_O);
endmodule

bind srap_port srap_port_checker i_srap_port_checker (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .ADDRESS_SELECT_PIN_I(ADDRESS_SELECT_PIN_I), .COEFF_O(COEFF_O));

/* verif/srap_mst.sv */
// Purpose: Bit-level 2-wire bus master for the serial register access port.
// Assumes: SDA has a pull-up outside; a high enable pulls it low.
// Notes:   SCL period 48 ns, resting high between frames.
`timescale 1ns/1ns
module srap_mst
(
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // Idle bus: both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One bit: data changes mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic s);
    sda_oe_o = !b;
    #12 scl_o = 1'b1;
    #12 s = sda_i;
    #12 scl_o = 1'b0;
    #12;
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start;
    sda_oe_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 sda_oe_o = 1'b1;
    #12 scl_o = 1'b0;
    #12;
  endtask
  // Stop, then a quiet gap so register updates land
  task automatic stop;
    sda_oe_o = 1'b1;
    #12 scl_o = 1'b1;
    #12 sda_oe_o = 1'b0;
    #200;
  endtask
  // Byte MSB first, then the ack slot with ms driven
  task automatic xfer(input logic [7:0] d, input logic ms, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ms, a);
  endtask
endmodule

/* verif/serial_register_access_port_tb_top.sv */
// Purpose: Self-checking bench for the serial register access port.
// Assumes: Strap pin high, so the device answers at {SLV_ADDR_HI, 1}, except
//          in the strap check, which drives it low for two frames.
// Notes:   A shadow image is compared on COEFF_O and by link reads.
`timescale 1ns/1ns
module serial_register_access_port_tb_top
  import srap_pkg::*;
;
  localparam logic [7:0] DEV_W = {SLV_ADDR_HI, 1'b1, 1'b0};
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 scl, m_oe, sda_oe, sda_o;
  logic                 sel = 1'b1;
  logic [8*CSC_NUM-1:0] coeff;
  logic [7:0]           shadow [CSC_NUM];
  int                   err_count = 0;
  int                   checked = 0;
  wire                  sda = !(m_oe || sda_oe);  // Wired-AND with pull-up
  // System clock, 40 ns
  initial
  begin
    forever #20 clk = ~clk;
  end
  srap_port i_srap_port (.CLK_I(clk), .NRST_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDRESS_SELECT_PIN_I(sel), .COEFF_O(coeff));
  srap_mst i_srap_mst (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_all;
    for (int i = 0; i < CSC_NUM; i++)
      check("coeff", coeff[8*i +: 8], shadow[i]);
    check("sda drive level", {7'h00, sda_o}, 8'h00);
  endtask
  // Start, device address, base address; returns both acks
  task automatic head(input logic [7:0] dev, input logic [7:0] base, output logic [1:0] ak);
    logic [7:0] q;
    i_srap_mst.start();
    i_srap_mst.xfer(dev, 1'b1, q, ak[1]);
    i_srap_mst.xfer(base, 1'b1, q, ak[0]);
    ak = ~ak;
  endtask
  task automatic wr(input logic [7:0] base, input logic [7:0] d[$]);
    logic [7:0] q;
    logic [1:0] ak;
    logic       a;
    int         p;
    head(DEV_W, base, ak);
    check("write head ack", {6'h00, ak}, 8'h03);
    foreach (d[i])
    begin
      i_srap_mst.xfer(d[i], 1'b1, q, a);
      check("write data ack", {7'h00, a}, 8'h00);
      p = (base + i > CSC_LAST) ? CSC_LAST : base + i;
      shadow[p - CSC_FIRST] = d[i];
    end
    i_srap_mst.stop();
    check_all();
  endtask
  task automatic rd_chk(input logic [7:0] base, input int n);
    logic [7:0] q;
    logic [1:0] ak;
    logic       a;
    int         p;
    head(DEV_W, base, ak);
    i_srap_mst.start();
    i_srap_mst.xfer(DEV_W | 8'h01, 1'b1, q, a);
    check("read head ack", {5'h00, ak, a}, 8'h06);
    for (int i = 0; i < n; i++)
    begin
      i_srap_mst.xfer(8'hff, i == n - 1, q, a);
      p = (base + i > CSC_LAST) ? CSC_LAST : base + i;
      check("read data", q, (p < CSC_FIRST) ? 8'h00 : shadow[p - CSC_FIRST]);
    end
    i_srap_mst.stop();
  endtask
  // Reset, also in mid-run, restores the default matrix
  task automatic scen_reset;
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    shadow = '{8'h0c, 8'h52, 8'h08, 8'h00, 8'h00, 8'h00, 8'h19, 8'hd7,
               8'h1c, 8'h54, 8'h08, 8'h00, 8'h3e, 8'h89, 8'h02, 8'h91,
               8'h00, 8'h00, 8'h08, 8'h00, 8'h0e, 8'h87, 8'h18, 8'hbd};
    check_all();
    repeat (2) @(posedge clk);
    rd_chk(CSC_FIRST, CSC_NUM);
  endtask
  // Refused device address and out-of-range bases leave registers alone
  task automatic scen_refuse;
    logic [7:0] q;
    logic [1:0] ak;
    logic       a;
    logic [7:0] dv [3] = '{DEV_W, DEV_W, DEV_W ^ 8'h02};
    logic [7:0] bs [3] = '{8'h4d, 8'hff, 8'h35};
    logic [1:0] ex [3] = '{2'b10, 2'b10, 2'b00};
    for (int i = 0; i < 3; i++)
    begin
      head(dv[i], bs[i], ak);
      check("refused ack", {6'h00, ak}, {6'h00, ex[i]});
      i_srap_mst.xfer(8'h00, 1'b1, q, a);
      i_srap_mst.stop();
    end
    // Strap low moves the device to the neighbouring address
    @(posedge clk);
    #1 sel = 1'b0;
    head(DEV_W, 8'h35, ak);
    check("strap old addr ack", {6'h00, ak}, 8'h00);
    i_srap_mst.stop();
    head(DEV_W ^ 8'h02, 8'h35, ak);
    check("strap new addr ack", {6'h00, ak}, 8'h03);
    i_srap_mst.stop();
    @(posedge clk);
    #1 sel = 1'b1;
    check_all();
  endtask
  // Main sequence
  initial
  begin
    scen_reset();
    wr(8'h3b, '{8'ha5});
    rd_chk(8'h3b, 1);
    wr(8'h35, '{8'h11, 8'h22, 8'h33, 8'h44});
    rd_chk(8'h33, 6);
    wr(8'h4b, '{8'h5a, 8'hc3, 8'h7e});
    rd_chk(8'h4b, 3);
    scen_refuse();
    scen_reset();
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
